// ===== inc/failsafe_map.svh
/*
 * Register offsets, field positions, reset values and timing figures of the
 * communication-loss fail-safe handler.
 * Assumes a 32-bit register port with byte addresses and word-aligned registers.
 */
`ifndef FAILSAFE_MAP_SVH
`define FAILSAFE_MAP_SVH

`define FS_OFS_CTRL      8'h00
`define FS_OFS_TIMEOUT   8'h04
`define FS_OFS_STATUS    8'h08
`define FS_OFS_MASK      8'h0C
`define FS_OFS_STATE     8'h10
`define FS_OFS_ACT_TMO   8'h14
`define FS_OFS_CRED      8'h18
`define FS_OFS_TABLE     8'h40

`define FS_CTRL_IDLE_ACT 0
`define FS_CTRL_REINIT   1

`define FS_ST_TIMEOUT    0
`define FS_ST_IDLE       1
`define FS_ST_DONE       2
`define FS_ST_LOGIN_FAIL 3
`define FS_ST_W          4

`define FS_TMO_DEFAULT   32'h0000_2710
`define FS_CRED_DEFAULT  32'h0000_0000
`define FS_TBL_ENTRIES   10
`define FS_CRED_MAX_LEN  80
`define FS_MS_NS         1000000
`define FS_CLK_NS        5
`define FS_CYC_PER_MS    (`FS_MS_NS / `FS_CLK_NS)

`endif

// ===== inc/failsafe_pkg.sv
/*
 * Types shared by the fail-safe handler files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package failsafe_pkg;
    typedef logic [15:0] word_t;
    typedef logic [31:0] reg_t;
    typedef enum logic [1:0] {ST_COPY, ST_RUN, ST_WALK_RD, ST_WALK_CHK} fs_state_t;
endpackage

// ===== rtl/fs_table_mem.sv
/*
 * Small table of code/value words with a registered read port.
 * Assumes one clock, async active-high reset and a clock enable from the owner.
 */
`timescale 1ns/10ps
module fs_table_mem #(
    parameter int DEPTH = 10,
    parameter int AW    = 4
) (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  reset,
    input  wire logic                  ce,
    // Write port
    input  wire logic                  wr_en,
    input  wire logic [AW-1:0]         wr_addr,
    input  wire failsafe_pkg::reg_t    wr_data,
    // Read port
    input  wire logic [AW-1:0]         rd_addr,
    output failsafe_pkg::reg_t         rd_data
);
    import failsafe_pkg::*;

    reg_t mem_r [DEPTH];

    // Cleared at reset so every entry starts with an empty code
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= 32'h0000_0000;
            end
            rd_data <= 32'h0000_0000;
        end else if (ce) begin
            if (wr_en && (int'(wr_addr) < DEPTH)) begin
                mem_r[wr_addr] <= wr_data;
            end
            rd_data <= (int'(rd_addr) < DEPTH) ? mem_r[rd_addr] : 32'h0000_0000;
        end
    end
endmodule

// ===== rtl/fs_pin_sync.sv
/*
 * Three-flop synchroniser for a pin level; the output moves only once the
 * second and third flops agree.
 * Assumes the pin is asynchronous to core_clk.
 */
`timescale 1ns/10ps
module fs_pin_sync (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic ce,
    // Level in and out
    input  wire logic pin,
    output logic      level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_nxt;

    always_comb begin
        level_nxt = (s2_r == s3_r) ? s3_r : level;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s1_r  <= 1'b0;
            s2_r  <= 1'b0;
            s3_r  <= 1'b0;
            level <= 1'b0;
        end else if (ce) begin
            s1_r  <= pin;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            level <= level_nxt;
        end
    end
endmodule

// ===== rtl/comm_loss_failsafe_handler.sv
/*
 * Communication-loss fail-safe handler: timeout watch, run/idle decode,
 * fail-safe table walk into the drive parameter space, boot-time load of
 * stored settings, credential checking and a register port with interrupt.
 * Assumes packet strobes come from network logic on core_clk, the reinit pin
 * is asynchronous, and the drive write port accepts one write per cycle.
 */
`timescale 1ns/10ps
`include "failsafe_map.svh"
module comm_loss_failsafe_handler #(
    parameter int CYC_PER_MS = `FS_CYC_PER_MS,
    parameter int ENTRIES    = `FS_TBL_ENTRIES
) (
    // Clock, reset, enable
    input  wire logic                  core_clk,
    input  wire logic                  reset,
    input  wire logic                  ce,
    // Register port
    input  wire logic [7:0]            addr,
    input  wire failsafe_pkg::reg_t    wdata,
    input  wire logic                  wr,
    input  wire logic                  rd,
    output failsafe_pkg::reg_t         rdata,
    output logic                       irq,
    // Received cyclic packets
    input  wire logic                  rx_valid,
    input  wire logic                  rx_hdr_en,
    input  wire failsafe_pkg::reg_t    rx_hdr,
    input  wire failsafe_pkg::word_t   rx_data,
    output failsafe_pkg::word_t        io_data,
    output logic                       run_flag,
    // Drive parameter writes
    output logic                       param_wr,
    output failsafe_pkg::word_t        param_code,
    output failsafe_pkg::word_t        param_val,
    // Reinit pin and boot state
    input  wire logic                  reinit_pin,
    output logic                       booted,
    // Login stream
    input  wire logic                  login_valid,
    input  wire logic [7:0]            login_char,
    input  wire logic                  login_sep,
    input  wire logic                  login_end,
    output logic                       login_ok
);
    import failsafe_pkg::*;

    localparam int AW = 4;

    fs_state_t  state_r, state_nxt;
    logic [AW-1:0] idx_r, idx_nxt;
    logic       cp_v_r, cp_v_nxt;
    reg_t       tmo_cfg_r, tmo_cfg_nxt, tmo_act_r, tmo_act_nxt;
    logic       idle_cfg_r, idle_cfg_nxt, idle_act_r, idle_act_nxt;
    logic [`FS_ST_W-1:0] status_r, status_nxt, mask_r, mask_nxt, st_set;
    reg_t       cred_r, cred_nxt, sig_r, sig_nxt;
    logic [6:0] len_r, len_nxt;
    logic       bad_r, bad_nxt;
    logic [31:0] pre_r, pre_nxt, elapsed_r, elapsed_nxt;
    logic       armed_r, armed_nxt, fired_r, fired_nxt, tick, tmo_evt;
    logic       idle_r, idle_nxt, idle_evt, walk_req_r, walk_req_nxt;
    logic       reinit_req_r, reinit_req_nxt, pin_lvl, pin_prev_r;
    logic       cfg_wr_seen_r, tbl_wr_seen_r;
    logic [1:0] loss_evt_r;
    reg_t       rdata_nxt, st_rd, act_rd;
    word_t      io_nxt, pcode_nxt, pval_nxt;
    logic       pwr_nxt, run_nxt, ok_nxt, alnum;
    logic       tbl_hit;
    logic [7:0] tbl_off;

    // Stored table written by software; active table loaded at boot
    assign tbl_off = addr - `FS_OFS_TABLE;
    assign tbl_hit = (addr >= `FS_OFS_TABLE) && (tbl_off[7:2] < 6'(ENTRIES))
                   && (tbl_off[1:0] == 2'b00);

    fs_table_mem #(.DEPTH(ENTRIES), .AW(AW)) u_stored (
        .core_clk (core_clk),
        .reset    (reset),
        .ce       (ce),
        .wr_en    (wr && tbl_hit),
        .wr_addr  (tbl_off[AW+1:2]),
        .wr_data  (wdata),
        .rd_addr  (idx_r),
        .rd_data  (st_rd)
    );

    fs_table_mem #(.DEPTH(ENTRIES), .AW(AW)) u_active (
        .core_clk (core_clk),
        .reset    (reset),
        .ce       (ce),
        .wr_en    (state_r == ST_COPY && cp_v_r),
        .wr_addr  (idx_r - 4'h1),
        .wr_data  (st_rd),
        .rd_addr  (idx_r),
        .rd_data  (act_rd)
    );

    fs_pin_sync u_pin (
        .core_clk (core_clk),
        .reset    (reset),
        .ce       (ce),
        .pin      (reinit_pin),
        .level    (pin_lvl)
    );

    // Timeout watch
    always_comb begin
        tick        = (pre_r == 32'(CYC_PER_MS - 1));
        pre_nxt     = tick ? 32'h0000_0000 : pre_r + 32'h0000_0001;
        elapsed_nxt = elapsed_r;
        armed_nxt   = armed_r | rx_valid;
        fired_nxt   = fired_r;
        tmo_evt     = 1'b0;
        if (rx_valid) begin
            pre_nxt     = 32'h0000_0000;
            elapsed_nxt = 32'h0000_0000;
            fired_nxt   = 1'b0;
        end else if (tick && armed_r && !fired_r && tmo_act_r != 32'h0000_0000) begin
            elapsed_nxt = elapsed_r + 32'h0000_0001;
            if (elapsed_nxt >= tmo_act_r) begin
                tmo_evt   = 1'b1;
                fired_nxt = 1'b1;
            end
        end
    end

    // Run/idle decode and held I/O data
    always_comb begin
        idle_nxt = idle_r;
        idle_evt = 1'b0;
        io_nxt   = io_data;
        run_nxt  = run_flag;
        if (rx_valid && rx_hdr_en) begin
            run_nxt  = rx_hdr[0];
            idle_nxt = !rx_hdr[0];
            idle_evt = !rx_hdr[0] && !idle_r;
        end
        // Idle packets never overwrite data, so fail-safe values are not undone
        if (rx_valid && !(rx_hdr_en && !rx_hdr[0])) begin
            io_nxt = rx_data;
        end
    end

    // Credential check: rolling signature keeps letter case distinct
    always_comb begin
        alnum   = (login_char >= 8'h30 && login_char <= 8'h39)
               || (login_char >= 8'h41 && login_char <= 8'h5A)
               || (login_char >= 8'h61 && login_char <= 8'h7A);
        sig_nxt = sig_r;
        len_nxt = len_r;
        bad_nxt = bad_r;
        ok_nxt  = 1'b0;
        if (login_valid) begin
            sig_nxt = {sig_r[30:0], sig_r[31]} ^ {24'h00_0000, login_char};
            len_nxt = len_r + 7'h01;
            bad_nxt = bad_r | !alnum | (len_r >= 7'(`FS_CRED_MAX_LEN));
        end
        if (login_sep) begin
            len_nxt = 7'h00;
        end
        if (login_end) begin
            ok_nxt  = !bad_r && (sig_r == cred_r);
            sig_nxt = 32'h0000_0000;
            len_nxt = 7'h00;
            bad_nxt = 1'b0;
        end
    end

    // Sequencer, registers and interrupt
    always_comb begin
        state_nxt      = state_r;
        idx_nxt        = idx_r;
        cp_v_nxt       = 1'b0;
        tmo_cfg_nxt    = tmo_cfg_r;
        idle_cfg_nxt   = idle_cfg_r;
        tmo_act_nxt    = tmo_act_r;
        idle_act_nxt   = idle_act_r;
        mask_nxt       = mask_r;
        cred_nxt       = cred_r;
        pwr_nxt        = 1'b0;
        pcode_nxt      = param_code;
        pval_nxt       = param_val;
        st_set         = '0;
        walk_req_nxt   = walk_req_r;
        reinit_req_nxt = reinit_req_r | (pin_lvl && !pin_prev_r);
        rdata_nxt      = 32'h0000_0000;
        st_set[`FS_ST_TIMEOUT]    = tmo_evt;
        st_set[`FS_ST_IDLE]       = idle_evt;
        st_set[`FS_ST_LOGIN_FAIL] = login_end && !ok_nxt;
        unique case (state_r)
            ST_COPY: begin
                idx_nxt  = idx_r + 4'h1;
                cp_v_nxt = (int'(idx_r) < ENTRIES);
                if (int'(idx_r) == ENTRIES) begin
                    tmo_act_nxt  = tmo_cfg_r;
                    idle_act_nxt = idle_cfg_r;
                    state_nxt    = ST_RUN;
                end
            end
            ST_RUN: begin
                idx_nxt = 4'h0;
                if (walk_req_r) begin
                    walk_req_nxt = 1'b0;
                    state_nxt    = ST_WALK_RD;
                end else if (reinit_req_r) begin
                    // A pin edge in the cycle the request is taken still counts
                    reinit_req_nxt = pin_lvl && !pin_prev_r;
                    state_nxt      = ST_COPY;
                end
            end
            ST_WALK_RD: state_nxt = ST_WALK_CHK;
            ST_WALK_CHK: begin
                if (act_rd[31:16] != 16'h0000) begin
                    pwr_nxt   = 1'b1;
                    pcode_nxt = act_rd[31:16];
                    pval_nxt  = act_rd[15:0];
                end
                idx_nxt   = idx_r + 4'h1;
                state_nxt = ST_WALK_RD;
                if (int'(idx_r) == ENTRIES - 1) begin
                    st_set[`FS_ST_DONE] = 1'b1;
                    state_nxt           = ST_RUN;
                end
            end
        endcase
        // A trigger in the cycle the walk starts is kept, not lost
        if (tmo_evt || (idle_evt && idle_act_r)) begin
            walk_req_nxt = 1'b1;
        end
        if (wr) begin
            unique case (addr)
                `FS_OFS_CTRL: begin
                    idle_cfg_nxt   = wdata[`FS_CTRL_IDLE_ACT];
                    reinit_req_nxt = reinit_req_nxt | wdata[`FS_CTRL_REINIT];
                end
                `FS_OFS_TIMEOUT: tmo_cfg_nxt = wdata;
                `FS_OFS_MASK:    mask_nxt    = wdata[`FS_ST_W-1:0];
                `FS_OFS_CRED:    cred_nxt    = wdata;
                default: ;
            endcase
        end
        status_nxt = status_r;
        if (wr && addr == `FS_OFS_STATUS) begin
            status_nxt = status_r & ~wdata[`FS_ST_W-1:0];
        end
        status_nxt = status_nxt | st_set;
        if (rd) begin
            unique case (addr)
                `FS_OFS_CTRL:    rdata_nxt = {31'h0000_0000, idle_cfg_r};
                `FS_OFS_TIMEOUT: rdata_nxt = tmo_cfg_r;
                `FS_OFS_STATUS:  rdata_nxt = {28'h000_0000, status_r};
                `FS_OFS_MASK:    rdata_nxt = {28'h000_0000, mask_r};
                `FS_OFS_STATE:   rdata_nxt = {26'h000_0000, idle_act_r, walk_req_r,
                                              reinit_req_r, run_flag, fired_r, booted};
                `FS_OFS_ACT_TMO: rdata_nxt = tmo_act_r;
                default:         rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_r       <= ST_COPY;
            idx_r         <= 4'h0;
            cp_v_r        <= 1'b0;
            tmo_cfg_r     <= `FS_TMO_DEFAULT;
            tmo_act_r     <= `FS_TMO_DEFAULT;
            idle_cfg_r    <= 1'b0;
            idle_act_r    <= 1'b0;
            status_r      <= '0;
            mask_r        <= '0;
            cred_r        <= `FS_CRED_DEFAULT;
            sig_r         <= 32'h0000_0000;
            len_r         <= 7'h00;
            bad_r         <= 1'b0;
            pre_r         <= 32'h0000_0000;
            elapsed_r     <= 32'h0000_0000;
            armed_r       <= 1'b0;
            fired_r       <= 1'b0;
            idle_r        <= 1'b0;
            walk_req_r    <= 1'b0;
            reinit_req_r  <= 1'b0;
            pin_prev_r    <= 1'b0;
            cfg_wr_seen_r <= 1'b0;
            tbl_wr_seen_r <= 1'b0;
            loss_evt_r    <= 2'h0;
            rdata         <= 32'h0000_0000;
            irq           <= 1'b0;
            io_data       <= 16'h0000;
            run_flag      <= 1'b0;
            param_wr      <= 1'b0;
            param_code    <= 16'h0000;
            param_val     <= 16'h0000;
            booted        <= 1'b0;
            login_ok      <= 1'b0;
        end else if (ce) begin
            state_r       <= state_nxt;
            idx_r         <= idx_nxt;
            cp_v_r        <= cp_v_nxt;
            tmo_cfg_r     <= tmo_cfg_nxt;
            tmo_act_r     <= tmo_act_nxt;
            idle_cfg_r    <= idle_cfg_nxt;
            idle_act_r    <= idle_act_nxt;
            status_r      <= status_nxt;
            mask_r        <= mask_nxt;
            cred_r        <= cred_nxt;
            sig_r         <= sig_nxt;
            len_r         <= len_nxt;
            bad_r         <= bad_nxt;
            pre_r         <= pre_nxt;
            elapsed_r     <= elapsed_nxt;
            armed_r       <= armed_nxt;
            fired_r       <= fired_nxt;
            idle_r        <= idle_nxt;
            walk_req_r    <= walk_req_nxt;
            reinit_req_r  <= reinit_req_nxt;
            pin_prev_r    <= pin_lvl;
            cfg_wr_seen_r <= cfg_wr_seen_r | (wr && addr == `FS_OFS_TIMEOUT);
            tbl_wr_seen_r <= tbl_wr_seen_r | (wr && tbl_hit);
            // Timeout events seen since the last packet, watched by one_event_a
            loss_evt_r    <= rx_valid ? 2'h0 : loss_evt_r + {1'b0, tmo_evt};
            rdata         <= rdata_nxt;
            irq           <= |(status_nxt & mask_nxt);
            io_data       <= io_nxt;
            run_flag      <= run_nxt;
            param_wr      <= pwr_nxt;
            param_code    <= pcode_nxt;
            param_val     <= pval_nxt;
            booted        <= (state_nxt != ST_COPY) | booted;
            login_ok      <= ok_nxt;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset || !ce);

    tmo_default_a: assert property (!cfg_wr_seen_r |-> tmo_cfg_r == `FS_TMO_DEFAULT)
        else $error("timeout default lost");
    tmo_event_a: assert property (tmo_evt |=> status_r[`FS_ST_TIMEOUT] && walk_req_r)
        else $error("timeout event not recorded");
    one_event_a: assert property (loss_evt_r <= 2'h1)
        else $error("second timeout in one loss");
    walk_write_a: assert property (state_r == ST_WALK_CHK && act_rd[31:16] != 16'h0000
        |=> param_wr && param_code == $past(act_rd[31:16])
            && param_val == $past(act_rd[15:0]))
        else $error("populated entry not written");
    walk_skip_a: assert property (state_r == ST_WALK_CHK && act_rd[31:16] == 16'h0000
        |=> !param_wr)
        else $error("empty entry written");
    empty_table_a: assert property (!tbl_wr_seen_r |-> !param_wr)
        else $error("write from default table");
    idle_hold_a: assert property (rx_valid && rx_hdr_en && !rx_hdr[0]
        |=> $stable(io_data))
        else $error("idle packet changed data");
    idle_walk_a: assert property (rx_valid && rx_hdr_en && !rx_hdr[0] && !idle_r && idle_act_r
        |=> walk_req_r ##1 state_r == ST_WALK_RD || walk_req_r)
        else $error("idle did not request walk");
    reinit_done_a: assert property ($rose(state_r == ST_COPY)
        |-> ##[1:20] state_r == ST_RUN)
        else $error("reinit too slow");
    act_stable_a: assert property (state_r != ST_COPY && $past(state_r) != ST_COPY
        |-> $stable(tmo_act_r) && $stable(idle_act_r))
        else $error("active settings changed while running");
    copy_traffic_a: assert property (state_r == ST_COPY && rx_valid && !rx_hdr_en
        |=> io_data == $past(rx_data))
        else $error("traffic stalled during reinit");
    login_bad_a: assert property (login_end && bad_r |=> !login_ok)
        else $error("bad credential accepted");

    walk_cov: cover property (state_r == ST_WALK_CHK && act_rd[31:16] != 16'h0000);
    reinit_cov: cover property (state_r == ST_RUN ##1 state_r == ST_COPY);
    idle_cov: cover property (idle_evt && idle_act_r);
endmodule

// ===== verif/plc_model.sv
/*
 * Cyclic I/O sender standing in for the network controller.
 * Assumes the handler's core_clk; every change lands just after a rising edge.
 */
`timescale 1ns/10ps
module plc_model (
    // Clock
    input  wire logic           core_clk,
    // Packet strobes
    output logic                rx_valid,
    output logic                rx_hdr_en,
    output failsafe_pkg::reg_t  rx_hdr,
    output failsafe_pkg::word_t rx_data
);
    import failsafe_pkg::*;
    initial begin
        rx_valid  = 1'b0;
        rx_hdr_en = 1'b0;
        rx_hdr    = 32'h0000_0000;
        rx_data   = 16'h0000;
    end
    // Kind 0 = no header, 1 = Run, 2 = Idle
    task automatic send(input logic [1:0] kind, input word_t d);
        @(posedge core_clk);
        rx_valid  <= 1'b1;
        rx_hdr_en <= (kind != 2'h0);
        rx_hdr    <= {31'h0, kind == 2'h1};
        rx_data   <= d;
        @(posedge core_clk);
        rx_valid  <= 1'b0;
        // Released lines flip so that a stale value never passes as a match
        rx_hdr    <= ~rx_hdr;
        rx_data   <= ~rx_data;
    endtask
endmodule

// ===== verif/testbench.sv
/*
 * Self-checking bench for the communication-loss fail-safe handler.
 * Assumes the plc_model sender and a 10-cycle millisecond to keep runs short.
 */
`timescale 1ns/10ps
`include "failsafe_map.svh"
module testbench;
    import failsafe_pkg::*;
    localparam int MS = 10;
    logic       core_clk, reset, ce, wr, rd, irq, rx_valid, rx_hdr_en, run_flag;
    logic       param_wr, reinit_pin, booted, login_valid, login_sep, login_end;
    logic       login_ok;
    logic [7:0] addr, login_char;
    reg_t       wdata, rdata, rx_hdr;
    word_t      rx_data, io_data, param_code, param_val;
    int         num_errors, n_compared;
    reg_t       pw_q[$];

    comm_loss_failsafe_handler #(.CYC_PER_MS(MS)) u_comm_loss_failsafe_handler (
        .core_clk, .reset, .ce, .addr, .wdata, .wr, .rd, .rdata, .irq,
        .rx_valid, .rx_hdr_en, .rx_hdr, .rx_data, .io_data, .run_flag,
        .param_wr, .param_code, .param_val, .reinit_pin, .booted,
        .login_valid, .login_char, .login_sep, .login_end, .login_ok);
    plc_model u_plc_model (.core_clk, .rx_valid, .rx_hdr_en, .rx_hdr, .rx_data);

    always @(posedge core_clk) begin
        if (param_wr === 1'b1) begin
            pw_q.push_back({param_code, param_val});
        end
    end

    task automatic chk(input string what, input reg_t got, input reg_t exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic reg_w(input logic [7:0] a, input reg_t d);
        @(posedge core_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr    <= 1'b0;
    endtask
    task automatic reg_r(input logic [7:0] a, output reg_t d);
        @(posedge core_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic reg_chk(input logic [7:0] a, input reg_t e, input string what);
        reg_t v;
        reg_r(a, v);
        chk(what, v, e);
    endtask
    // Polls a register field; a field that never settles ends the run
    task automatic wait_reg(input logic [7:0] a, input reg_t m, input reg_t e);
        reg_t v;
        for (int i = 0; i < 200; i++) begin
            reg_r(a, v);
            if ((v & m) === e) return;
        end
        chk("poll", v & m, e);
        test_done();
    endtask
    task automatic login(input logic [7:0] c, input logic e);
        @(posedge core_clk);
        login_valid <= 1'b1;
        login_char  <= c;
        @(posedge core_clk);
        login_valid <= 1'b0;
        login_end   <= 1'b1;
        @(posedge core_clk);
        login_end   <= 1'b0;
        #1 chk("login_ok", {31'h0, login_ok}, {31'h0, e});
    endtask

    task automatic t_reset();
        wait_reg(`FS_OFS_STATE, 32'h1, 32'h1);
        chk("booted", {31'h0, booted}, 32'h1);
        reg_chk(`FS_OFS_TIMEOUT, 32'h0000_2710, "stored timeout");
        reg_chk(`FS_OFS_ACT_TMO, 32'h0000_2710, "active timeout");
        reg_chk(`FS_OFS_STATUS, 32'h0, "status");
        reg_chk(8'h3C, 32'h0, "unmapped read");
        $display("test reset done");
    endtask
    task automatic t_boot_cfg();
        reg_w(`FS_OFS_TIMEOUT, 32'hFFFF_FFFF);
        reg_chk(`FS_OFS_TIMEOUT, 32'hFFFF_FFFF, "timeout width");
        reg_w(`FS_OFS_TIMEOUT, 32'h3);
        reg_chk(`FS_OFS_ACT_TMO, 32'h0000_2710, "active before reinit");
        reg_w(`FS_OFS_CTRL, 32'h2);
        u_plc_model.send(2'h0, 16'h00AA);
        #1 chk("io_data in reinit", {16'h0, io_data}, 32'hAA);
        wait_reg(`FS_OFS_ACT_TMO, 32'hFFFF_FFFF, 32'h3);
        $display("test boot_cfg done");
    endtask
    task automatic t_empty();
        // Silence after the last packet fires once, and the empty table writes nothing
        wait_reg(`FS_OFS_STATUS, 32'h5, 32'h5);
        chk("empty table writes", pw_q.size(), 32'h0);
        reg_w(`FS_OFS_STATUS, 32'hF);
        reg_w(`FS_OFS_MASK, 32'h1);
        repeat (60) @(posedge core_clk);
        reg_chk(`FS_OFS_STATUS, 32'h0, "second event");
        $display("test empty done");
    endtask
    task automatic t_table();
        int n;
        reg_t v;
        reg_w(`FS_OFS_TABLE, 32'h0005_07D0);
        reg_w(`FS_OFS_TABLE + 8'h24, 32'h0009_1234);
        reg_w(`FS_OFS_TABLE + 8'h28, 32'h000B_5555);
        reg_chk(`FS_OFS_TABLE, 32'h0, "table read");
        reg_w(`FS_OFS_TIMEOUT, 32'h4);
        reg_w(`FS_OFS_CTRL, 32'h2);
        wait_reg(`FS_OFS_ACT_TMO, 32'hFFFF_FFFF, 32'h4);
        pw_q.delete();
        repeat (3) begin
            u_plc_model.send(2'h0, 16'h0002);
            repeat (30) @(posedge core_clk);
        end
        chk("irq with traffic", {31'h0, irq}, 32'h0);
        u_plc_model.send(2'h0, 16'h0003);
        n = 0;
        while (irq !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("timeout delay", {31'h0, n >= 4 * MS - 2 && n <= 4 * MS + 12}, 32'h1);
        if (n == 200) test_done();
        wait_reg(`FS_OFS_STATUS, 32'h4, 32'h4);
        chk("walk writes", pw_q.size(), 32'h2);
        chk("entry 0", pw_q[0], 32'h0005_07D0);
        chk("entry 9", pw_q[1], 32'h0009_1234);
        reg_w(`FS_OFS_STATUS, 32'hF);
        $display("test table done");
    endtask
    task automatic t_idle();
        pw_q.delete();
        u_plc_model.send(2'h1, 16'h0011);
        #1 chk("run_flag run", {31'h0, run_flag}, 32'h1);
        u_plc_model.send(2'h2, 16'h0022);
        #1 chk("io_data idle", {16'h0, io_data}, 32'h11);
        chk("run_flag idle", {31'h0, run_flag}, 32'h0);
        repeat (15) @(posedge core_clk);
        reg_chk(`FS_OFS_STATUS, 32'h2, "idle event");
        chk("idle writes", pw_q.size(), 32'h0);
        // Idle action on, timeout off, reinit from the pin this time
        reg_w(`FS_OFS_CTRL, 32'h1);
        reg_w(`FS_OFS_TIMEOUT, 32'h0);
        reinit_pin <= 1'b1;
        repeat (6) @(posedge core_clk);
        reinit_pin <= 1'b0;
        wait_reg(`FS_OFS_STATE, 32'h20, 32'h20);
        wait_reg(`FS_OFS_ACT_TMO, 32'hFFFF_FFFF, 32'h0);
        reg_w(`FS_OFS_STATUS, 32'hF);
        pw_q.delete();
        u_plc_model.send(2'h1, 16'h0033);
        u_plc_model.send(2'h2, 16'h0044);
        repeat (30) @(posedge core_clk);
        chk("idle walk writes", pw_q.size(), 32'h2);
        reg_chk(`FS_OFS_STATUS, 32'h6, "idle walk status");
        $display("test idle done");
    endtask
    task automatic t_login();
        reg_w(`FS_OFS_STATUS, 32'hF);
        reg_w(`FS_OFS_CRED, 32'h0000_0041);
        login(8'h41, 1'b1);
        login(8'h61, 1'b0);
        reg_w(`FS_OFS_CRED, 32'h0000_002D);
        login(8'h2D, 1'b0);
        reg_chk(`FS_OFS_STATUS, 32'h8, "login fail");
        $display("test login done");
    endtask

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        num_errors  = 0;
        n_compared  = 0;
        reset       = 1'b1;
        ce          = 1'b1;
        addr        = 8'h00;
        wdata       = 32'h0;
        wr          = 1'b0;
        rd          = 1'b0;
        reinit_pin  = 1'b0;
        login_valid = 1'b0;
        login_char  = 8'h00;
        login_sep   = 1'b0;
        login_end   = 1'b0;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        t_reset();
        t_boot_cfg();
        t_empty();
        t_table();
        t_idle();
        t_login();
        test_done();
    end
endmodule
